// >>> rtl/ipf_pkg.sv
package ipf_pkg;

  // ==========================================================================
  // Register map (word offsets on the plain register port).
  // ==========================================================================
  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  OFF_CORE_CTRL   = 4'h0;
  localparam logic [3:0]  OFF_FLAGS_TWO   = 4'h1;
  localparam logic [3:0]  OFF_ENABLES_3   = 4'h2;
  localparam logic [3:0]  OFF_PSW         = 4'h3;
  localparam logic [3:0]  OFF_IRQ_STATUS  = 4'h4;
  localparam logic [3:0]  OFF_IRQ_MASK    = 4'h5;

  // ==========================================================================
  // Field positions and masks.
  // ==========================================================================
  localparam int unsigned CC_EXT_BIT      = 3;
  localparam int unsigned CC_RSVD_BIT     = 2;
  localparam int unsigned PSW_LOW_LSB     = 5;
  localparam logic [3:0]  PRIO_THRESHOLD  = 4'h7;
  // Implemented bits of the flag register (bits 15, 12 and 11 absent).
  localparam logic [15:0] FLAGS_TWO_MASK  = 16'h67ff;
  // Implemented bits of the enable register (bits 15, 9, 4, 3, 0 absent).
  localparam logic [15:0] ENABLES_3_MASK  = 16'h7de6;
  localparam int unsigned EN_EXT4_BIT     = 6;
  localparam int unsigned EN_EXT3_BIT     = 5;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [15:0] RST_FLAGS_TWO   = 16'h0000;
  localparam logic [15:0] RST_ENABLES_3   = 16'h0000;
  localparam logic [15:0] RST_PSW         = 16'h0000;
  localparam logic [1:0]  RST_IRQ         = 2'h0;

  // Local event bits of the block's own status and mask registers.
  localparam int unsigned EV_PRIO_UP      = 0;
  localparam int unsigned EV_REQ_ROSE     = 1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
    logic              wr;
    logic              rd;
  } ipf_bus_t;

endpackage : ipf_pkg

// >>> rtl/ipf_regslice.sv
`timescale 1ns/100ps

// Generic 16-bit register slice: write with mask, hardware set wins over clear.
module ipf_regslice #(
  parameter logic [15:0] MASK  = 16'hffff,
  parameter logic [15:0] RESET = 16'h0000
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [15:0] set_i,
  output logic      [15:0] q_o
);

  logic [15:0] q_d;

  // ==========================================================================
  // Next value: a write replaces the word, then hardware sets are ORed in so
  // an event in the same cycle as a software clear is never lost.
  // ==========================================================================
  always_comb begin
    q_d = q_o;
    if (wr_i) begin
      q_d = wdata_i;
    end
    q_d = (q_d | set_i) & MASK;
  end

  // Register stage.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q_o <= RESET;
    end else begin
      q_o <= q_d;
    end
  end

endmodule : ipf_regslice

// >>> rtl/ipf_top.sv
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps

// What this block does
// - The priority extension bit reads one when the core priority level exceeds 7 and zero otherwise.
// - The four-bit core priority is the extension bit above the three low bits held in status word bits 7 to 5.
// - Bit 2 of the core control register always reads one and ignores writes.
// - Bits 15 to 4 of the core control register read zero and ignore writes.
// - Bits 1 and 0 of the core control register read zero.
module ipf_top (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  input  wire logic [ipf_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [15:0]                wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  input  wire logic [3:0]                 core_prio_i,
  input  wire logic [15:0]                src_flag_set_i,
  input  wire logic [15:0]                src_enable_req_i,
  input  wire logic                       ext4_routed_i,
  input  wire logic                       ext3_routed_i,
  output logic      [15:0]                rdata_o,
  output logic      [3:0]                 cpu_prio_o,
  output logic      [15:0]                flag_req_o,
  output logic      [15:0]                enable_req_o,
  output logic                            irq_o
);

  ipf_pkg::ipf_bus_t bus;
  logic [15:0]       flags_q;
  logic [15:0]       enables_q;
  logic [15:0]       psw_q;
  logic [15:0]       psw_d;
  logic [15:0]       irq_stat_q;
  logic [15:0]       irq_mask_q;
  logic [15:0]       irq_set;
  logic [15:0]       stat_wdata;
  logic [15:0]       en_wdata;
  logic              stat_wr;
  logic [3:0]        prio_q;
  logic [3:0]        prio_d;
  logic              req_any_q;
  logic              req_any_d;
  logic [15:0]       rdata_d;
  logic [15:0]       flag_req_d;
  logic [15:0]       enable_req_d;
  logic              irq_d;

  // Returns one when the register port writes the given word offset.
  function automatic logic hit(input ipf_pkg::ipf_bus_t b, input logic [3:0] off);
    hit = b.wr && (b.addr == off);
  endfunction : hit

  // Priority extension bit from a four-bit level.
  function automatic logic prio_ext(input logic [3:0] lvl);
    prio_ext = (lvl > ipf_pkg::PRIO_THRESHOLD);
  endfunction : prio_ext

  // Core control readback: only the extension and reserved bits exist.
  function automatic logic [15:0] core_ctrl_word(input logic [3:0] lvl);
    logic [15:0] w;
    w = 16'h0000;
    w[ipf_pkg::CC_EXT_BIT]  = prio_ext(lvl);
    w[ipf_pkg::CC_RSVD_BIT] = 1'b1;
    core_ctrl_word = w;
  endfunction : core_ctrl_word

  always_comb begin
    bus.addr  = addr_i;
    bus.wdata = wdata_i;
    bus.wr    = wr_i;
    bus.rd    = rd_i;
  end

  // ==========================================================================
  // Flag and enable registers.
  // ==========================================================================
  // Writes to the enable register drop external enables whose input has no
  // remappable pin, since such an enable could never see an event.
  always_comb begin
    en_wdata = bus.wdata;
    en_wdata[ipf_pkg::EN_EXT4_BIT] = bus.wdata[ipf_pkg::EN_EXT4_BIT] & ext4_routed_i;
    en_wdata[ipf_pkg::EN_EXT3_BIT] = bus.wdata[ipf_pkg::EN_EXT3_BIT] & ext3_routed_i;
  end

  ipf_regslice #(
    .MASK  (ipf_pkg::FLAGS_TWO_MASK),
    .RESET (ipf_pkg::RST_FLAGS_TWO)
  ) u_flags (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .wr_i      (hit(bus, ipf_pkg::OFF_FLAGS_TWO)),
    .wdata_i   (bus.wdata),
    .set_i     (src_flag_set_i),
    .q_o       (flags_q)
  );

  ipf_regslice #(
    .MASK  (ipf_pkg::ENABLES_3_MASK),
    .RESET (ipf_pkg::RST_ENABLES_3)
  ) u_enables (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .wr_i      (hit(bus, ipf_pkg::OFF_ENABLES_3)),
    .wdata_i   (en_wdata),
    .set_i     (16'h0000),
    .q_o       (enables_q)
  );

  // ==========================================================================
  // Processor status word and priority level.
  // ==========================================================================
  // The status word holds the low priority bits; the core supplies the full
  // level, and the extension bit is recomputed from it every cycle.
  always_comb begin
    psw_d = psw_q;
    if (hit(bus, ipf_pkg::OFF_PSW)) begin
      psw_d = bus.wdata;
    end
    psw_d[ipf_pkg::PSW_LOW_LSB +: 3] = core_prio_i[2:0];
    prio_d = {prio_ext(core_prio_i), psw_d[ipf_pkg::PSW_LOW_LSB +: 3]};
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      psw_q  <= ipf_pkg::RST_PSW;
      prio_q <= 4'h0;
    end else begin
      psw_q  <= psw_d;
      prio_q <= prio_d;
    end
  end

  // ==========================================================================
  // Local interrupt status: write one to clear, set wins.
  // ==========================================================================
  always_comb begin
    req_any_d = |(flags_q & enables_q);
    irq_set   = 16'h0000;
    irq_set[ipf_pkg::EV_PRIO_UP]  = prio_ext(prio_d) & ~prio_ext(prio_q);
    irq_set[ipf_pkg::EV_REQ_ROSE] = req_any_d & ~req_any_q;
    stat_wr    = hit(bus, ipf_pkg::OFF_IRQ_STATUS);
    stat_wdata = irq_stat_q & ~bus.wdata;
  end

  ipf_regslice #(
    .MASK  (16'h0003),
    .RESET (16'h0000)
  ) u_irq_stat (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .wr_i      (stat_wr),
    .wdata_i   (stat_wdata),
    .set_i     (irq_set),
    .q_o       (irq_stat_q)
  );

  ipf_regslice #(
    .MASK  (16'h0003),
    .RESET (16'h0000)
  ) u_irq_mask (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .wr_i      (hit(bus, ipf_pkg::OFF_IRQ_MASK)),
    .wdata_i   (bus.wdata),
    .set_i     (16'h0000),
    .q_o       (irq_mask_q)
  );

  // ==========================================================================
  // Outputs and read mux, all registered.
  // ==========================================================================
  always_comb begin
    flag_req_d   = flags_q & enables_q;
    enable_req_d = enables_q;
    irq_d        = |(irq_stat_q & irq_mask_q);
    rdata_d      = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        ipf_pkg::OFF_CORE_CTRL:  rdata_d = core_ctrl_word(prio_q);
        ipf_pkg::OFF_FLAGS_TWO:  rdata_d = flags_q;
        ipf_pkg::OFF_ENABLES_3:  rdata_d = enables_q;
        ipf_pkg::OFF_PSW:        rdata_d = psw_q;
        ipf_pkg::OFF_IRQ_STATUS: rdata_d = irq_stat_q;
        ipf_pkg::OFF_IRQ_MASK:   rdata_d = irq_mask_q;
        default:                 rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o      <= 16'h0000;
      cpu_prio_o   <= 4'h0;
      flag_req_o   <= 16'h0000;
      enable_req_o <= 16'h0000;
      irq_o        <= 1'b0;
      req_any_q    <= 1'b0;
    end else begin
      rdata_o      <= rdata_d;
      cpu_prio_o   <= prio_q;
      flag_req_o   <= flag_req_d;
      enable_req_o <= enable_req_d;
      irq_o        <= irq_d;
      req_any_q    <= req_any_d;
    end
  end

endmodule : ipf_top

// >>> tb/ipf_properties.sv
`timescale 1ns/100ps

// ==========================================
// Port checker for the priority and flag block.
module ipf_chk (
  input wire logic                       clk_sys_i,
  input wire logic                       rst_i,
  input wire logic [ipf_pkg::ADDR_W-1:0] addr_i,
  input wire logic                       wr_i,
  input wire logic                       rd_i,
  input wire logic [3:0]                 core_prio_i,
  input wire logic                       ext4_routed_i,
  input wire logic [15:0]                rdata_o,
  input wire logic [3:0]                 cpu_prio_o,
  input wire logic [15:0]                flag_req_o,
  input wire logic [15:0]                enable_req_o,
  input wire logic                       irq_o
);
  logic [2:0] age_q;
  logic       rdc_q;
  // Edges since reset, so history checks never look back into reset.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      age_q <= 3'h0;
      rdc_q <= 1'b0;
    end else begin
      age_q <= (age_q == 3'h7) ? age_q : age_q + 3'h1;
      rdc_q <= rd_i && (addr_i == ipf_pkg::OFF_CORE_CTRL);
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  a_ctl_rsvd_one: assert property (rdc_q |-> rdata_o[2])
    else $error("Reserved control bit read zero.");
  a_ctl_upper_zero: assert property (rdc_q |-> rdata_o[15:4] == 12'h000)
    else $error("Upper control bits not zero.");
  a_ctl_low_zero: assert property (rdc_q |-> rdata_o[1:0] == 2'h0)
    else $error("Low control bits not zero.");
  // Only judged on a steady level, which keeps the check free of pipeline guesses.
  a_ctl_ext_bit: assert property (rdc_q && age_q > 3'h3 && $past(core_prio_i) == $past(core_prio_i, 2)
    && $past(core_prio_i, 2) == $past(core_prio_i, 3) |-> rdata_o[3] == ($past(core_prio_i) > 4'h7))
    else $error("Extension bit wrong.");
  a_prio_concat: assert property (age_q > 3'h2 |-> cpu_prio_o == $past(core_prio_i, 2))
    else $error("Four-bit priority wrong.");
  a_req_gated: assert property ((flag_req_o & ~enable_req_o) == 16'h0000)
    else $error("Request without enable.");
  // A flag write lands one edge later and shows on the request output one edge after that.
  a_flag_sticky: assert property (age_q > 3'h1
    && !($past(wr_i, 2) && $past(addr_i, 2) == ipf_pkg::OFF_FLAGS_TWO) |->
    ($past(flag_req_o) & enable_req_o & ~flag_req_o) == 16'h0000)
    else $error("Flag dropped without a write.");
  a_ext_routed: assert property ($rose(enable_req_o[ipf_pkg::EN_EXT4_BIT]) |-> $past(ext4_routed_i, 2))
    else $error("Unrouted external enable set.");
  c_ctl_read: cover property (rdc_q);
  c_irq: cover property (irq_o);
  c_req: cover property (|flag_req_o);
endmodule : ipf_chk

bind ipf_top ipf_chk i_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
  .core_prio_i(core_prio_i), .ext4_routed_i(ext4_routed_i), .rdata_o(rdata_o),
  .cpu_prio_o(cpu_prio_o), .flag_req_o(flag_req_o), .enable_req_o(enable_req_o), .irq_o(irq_o)
);

// >>> tb/ipf_core_model.sv
`timescale 1ns/100ps

// ==========================================
// Processor core stand-in on the far side.
module ipf_core_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] prio_want_i,
  input  wire logic       route_i,
  output logic      [3:0] core_prio_o,
  output logic            ext4_routed_o,
  output logic            ext3_routed_o
);
  // The level moves only on a clock edge, as a real core would move it.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) core_prio_o <= 4'h0;
    else core_prio_o <= prio_want_i;
  end
  // Both external inputs are mapped to pins together; unmapped they stay dead.
  assign ext4_routed_o = route_i;
  assign ext3_routed_o = route_i;
endmodule : ipf_core_model

// >>> tb/testbench.sv
`timescale 1ns/100ps

// ==========================================
// Bench: register port, priority sweep, flags and interrupt.
module testbench;
  logic        clk_sys_i, rst, wr, rd, route, irq, r4, r3;
  logic [3:0]  addr, prio_want, core_prio, cpu_prio;
  logic [15:0] wdata, fset, rdata, freq, ereq, rnd, fl_exp, en_exp;
  int          err_count, checks;
  ipf_top i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .core_prio_i(core_prio), .src_flag_set_i(fset), .src_enable_req_i(16'h0000),
    .ext4_routed_i(r4), .ext3_routed_i(r3), .rdata_o(rdata), .cpu_prio_o(cpu_prio),
    .flag_req_o(freq), .enable_req_o(ereq), .irq_o(irq)
  );
  ipf_core_model i_core (
    .clk_sys_i(clk_sys_i), .rst_i(rst), .prio_want_i(prio_want), .route_i(route),
    .core_prio_o(core_prio), .ext4_routed_o(r4), .ext3_routed_o(r3)
  );
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Enable image: unrouted external inputs never take a one.
  function automatic logic [15:0] exp_en(input logic [15:0] d, input logic rt);
    return d & ipf_pkg::ENABLES_3_MASK & (rt ? 16'hffff : 16'hff9f);
  endfunction : exp_en
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wreg
  // Read data stand for one cycle only, so they are taken just after the answer edge.
  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk_sys_i);
  endtask : rreg
  task automatic finish_test();
    $display("checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic wait_irq(input logic lvl);
    repeat (20) begin
      #1;
      if (irq === lvl) break;
      @(posedge clk_sys_i);
    end
    chk({15'h0, irq}, {15'h0, lvl});
    if (irq !== lvl) begin
      finish_test();
    end else begin
      @(posedge clk_sys_i);
    end
  endtask : wait_irq
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    {rst, wr, rd, route, addr, prio_want} = 12'h800;
    {wdata, fset, fl_exp} = 48'h0;
    err_count = 0;
    checks = 0;
    rnd = 16'h0062;
    repeat (5) @(posedge clk_sys_i);
    rst <= 1'b0;
    @(posedge clk_sys_i);
    // Reset images, an unmapped offset, and a control write that must not stick.
    for (int a = 1; a < 6; a++) rreg(a[3:0], 16'h0000);
    rreg(4'hf, 16'h0000);
    wreg(ipf_pkg::OFF_CORE_CTRL, 16'hffff);
    rreg(ipf_pkg::OFF_CORE_CTRL, 16'h0004);
    // Sweep every level; crossing seven also latches status bit zero.
    for (int p = 0; p < 16; p++) begin
      prio_want <= p[3:0];
      repeat (4) @(posedge clk_sys_i);
      rreg(ipf_pkg::OFF_CORE_CTRL, (p > 7) ? 16'h000c : 16'h0004);
      chk({12'h000, cpu_prio}, {12'h000, p[3:0]});
      rreg(ipf_pkg::OFF_PSW, {8'h00, p[2:0], 5'h00});
    end
    // A status word write keeps its other bits, but the low priority bits follow the core.
    wreg(ipf_pkg::OFF_PSW, 16'h1234);
    rreg(ipf_pkg::OFF_PSW, 16'h12f4);
    rreg(ipf_pkg::OFF_IRQ_STATUS, 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    wreg(ipf_pkg::OFF_IRQ_MASK, 16'h0001);
    wait_irq(1'b1);
    wreg(ipf_pkg::OFF_IRQ_STATUS, 16'h0001);
    wait_irq(1'b0);
    wreg(ipf_pkg::OFF_ENABLES_3, 16'hffff);
    rreg(ipf_pkg::OFF_ENABLES_3, exp_en(16'hffff, 1'b0));
    route <= 1'b1;
    wreg(ipf_pkg::OFF_ENABLES_3, 16'hffff);
    rreg(ipf_pkg::OFF_ENABLES_3, exp_en(16'hffff, 1'b1));
    // A new enabled flag raises the interrupt; clearing status drops it.
    wreg(ipf_pkg::OFF_IRQ_MASK, 16'h0002);
    fset <= 16'h0002;
    @(posedge clk_sys_i);
    fset <= 16'h0000;
    fl_exp = 16'h0002;
    wait_irq(1'b1);
    wreg(ipf_pkg::OFF_IRQ_STATUS, 16'h0002);
    wait_irq(1'b0);
    // Random flags and enables; flags stay until software writes them away.
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      fset <= rnd & ipf_pkg::FLAGS_TWO_MASK;
      @(posedge clk_sys_i);
      fset <= 16'h0000;
      fl_exp = fl_exp | (rnd & ipf_pkg::FLAGS_TWO_MASK);
      rnd = lfsr(rnd);
      wreg(ipf_pkg::OFF_ENABLES_3, rnd);
      en_exp = exp_en(rnd, 1'b1);
      rreg(ipf_pkg::OFF_FLAGS_TWO, fl_exp);
      chk(freq, fl_exp & en_exp);
      chk(ereq, en_exp);
      if (rnd[0]) begin
        wreg(ipf_pkg::OFF_FLAGS_TWO, 16'h0000);
        fl_exp = 16'h0000;
      end
    end
    finish_test();
  end
endmodule : testbench
